// [common/light_prox_params.svh]
// Constants for the interrupt status and result byte registers.
// Assumes an 8-bit register port addressed as the host sees it.
`ifndef LIGHT_PROX_PARAMS_SVH
`define LIGHT_PROX_PARAMS_SVH

// Register addresses
`define ADDR_IRQ_FLAGS 8'h21
`define ADDR_VIS_LO 8'h22
`define ADDR_VIS_HI 8'h23
`define ADDR_IR_LO 8'h24
`define ADDR_IR_HI 8'h25
`define ADDR_PS1_LO 8'h26
`define ADDR_PS1_HI 8'h27
`define ADDR_PS2_LO 8'h28
`define ADDR_PS2_HI 8'h29

// Field positions inside the interrupt status byte
`define BIT_CMD 5
`define BIT_PS3 4
`define BIT_PS2 3
`define BIT_PS1 2
`define ALS_HI 1
`define ALS_LO 0
`define FLAG_W 6

// Reset values and codes
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_FLAGS 6'h00
`define COND_KEEP 2'h3

// Result slots in the result array
`define SLOT_VIS 0
`define SLOT_IR 1
`define SLOT_PS1 2
`define SLOT_PS2 3
`define SLOT_N 4

`endif

// [common/light_prox_pkg.sv]
// Types shared by the status and result block.
// Assumes the params header is on the include path.
`default_nettype none

package light_prox_pkg;

  // Which measurement finished
  typedef enum logic [2:0] {
    CH_VIS,
    CH_IR,
    CH_PS1,
    CH_PS2,
    CH_PS3
  } meas_chan_t;

  // One completed measurement from the sequencer
  typedef struct packed {
    logic valid;
    meas_chan_t chan;
    logic [15:0] value;
    logic [1:0] als_code;
  } meas_t;

  // One register access from the serial register port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : light_prox_pkg

`default_nettype wire

// [core/light_prox_irq_results.sv]
// Interrupt status flags, interrupt line and 16-bit result byte registers.
// Assumes the serial register engine and the sequencer share clk_sys.
`include "light_prox_params.svh"
`default_nettype none

// Function
// RQ1 - Status byte: cmd bit5, proximity 4..2, ambient 1:0
// RQ2 - Interrupt when any enabled flag is set
// RQ3 - Policy 0: host writes one to clear
// RQ4 - Policy 1: auto clear, except condition 11
// RQ5 - Host reads results before next measurement
// RQ6 - Visible result at 0x22 low, 0x23 high
// RQ7 - Infrared result at 0x24 low, 0x25 high
// RQ8 - Proximity one result at 0x26, 0x27
// RQ9 - Proximity two low byte at 0x28
// RQ10 - All status and results reset to zero
// RQ11 - Proximity two high byte at 0x29
// RQ12 - Both bytes and flag update together
module light_prox_irq_results
  import light_prox_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port from the serial engine
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Sequencer events
  input wire meas_t meas,
  input wire logic cmd_done,
  input wire logic auto_clear,
  // Configuration held elsewhere
  input wire logic [5:0] irq_enable,
  input wire logic int_mode,
  input wire logic [1:0] proximity_irq_condition [3],
  // Host interrupt line
  output logic host_int
);

  // Flag storage, bits 7:6 are never stored
  logic [5:0] flags_r;
  logic [5:0] flags_nxt;
  // Result words: visible, infrared, proximity one, proximity two
  logic [15:0] res_r [`SLOT_N];
  logic [15:0] res_nxt [`SLOT_N];
  // Read data and interrupt level
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic int_r;
  logic int_nxt;
  // Set and clear masks for this cycle
  logic [5:0] set_mask;
  logic [5:0] clr_mask;
  logic status_wr;

  // Status write strobe, shared by the host clear and the held-flag path
  assign status_wr = reg_req.wr && (reg_req.addr == `ADDR_IRQ_FLAGS);

  // Flag next value: events set, host or sequencer clears, set wins
  // A clear landing in the cycle of its own event must never lose the event
  always_comb begin
    set_mask = `RST_FLAGS;
    clr_mask = `RST_FLAGS;
    if (meas.valid) begin
      case (meas.chan)
        CH_VIS, CH_IR: set_mask[`ALS_HI:`ALS_LO] = meas.als_code; // [RQ1]
        CH_PS1: set_mask[`BIT_PS1] = 1'b1; // [RQ12]
        CH_PS2: set_mask[`BIT_PS2] = 1'b1; // [RQ12]
        CH_PS3: set_mask[`BIT_PS3] = 1'b1; // [RQ1]
        default: set_mask = `RST_FLAGS;
      endcase
    end
    if (cmd_done) begin
      set_mask[`BIT_CMD] = 1'b1; // [RQ1]
    end
    // Write one to a flag bit clears it
    if (status_wr) begin
      clr_mask = reg_req.wdata[5:0]; // [RQ3]
    end
    // Automatic policy clears all but proximity flags held by condition 11
    // A held proximity flag still answers a host write of one
    if (int_mode && auto_clear) begin
      clr_mask = {6{1'b1}}; // [RQ4]
      if (proximity_irq_condition[0] == `COND_KEEP) begin
        clr_mask[`BIT_PS1] = status_wr & reg_req.wdata[`BIT_PS1]; // [RQ4]
      end
      if (proximity_irq_condition[1] == `COND_KEEP) begin
        clr_mask[`BIT_PS2] = status_wr & reg_req.wdata[`BIT_PS2]; // [RQ4]
      end
      if (proximity_irq_condition[2] == `COND_KEEP) begin
        clr_mask[`BIT_PS3] = status_wr & reg_req.wdata[`BIT_PS3]; // [RQ4]
      end
    end
    flags_nxt = (flags_r & ~clr_mask) | set_mask; // [RQ3]
    // Line follows the next flags, so it drops in the very cycle a clear lands
    int_nxt = |(flags_nxt & irq_enable); // [RQ2]
  end

  // Result next value: host byte writes, measurement loads whole word
  // A host byte write on a channel that finishes in the same cycle is lost
  always_comb begin
    for (int i = 0; i < `SLOT_N; i++) begin
      res_nxt[i] = res_r[i];
    end
    // Host may overwrite a byte
    if (reg_req.wr) begin
      if (reg_req.addr == `ADDR_VIS_LO) begin
        res_nxt[`SLOT_VIS][7:0] = reg_req.wdata;
      end else if (reg_req.addr == `ADDR_VIS_HI) begin
        res_nxt[`SLOT_VIS][15:8] = reg_req.wdata;
      end else if (reg_req.addr == `ADDR_IR_LO) begin
        res_nxt[`SLOT_IR][7:0] = reg_req.wdata;
      end else if (reg_req.addr == `ADDR_IR_HI) begin
        res_nxt[`SLOT_IR][15:8] = reg_req.wdata;
      end else if (reg_req.addr == `ADDR_PS1_LO) begin
        res_nxt[`SLOT_PS1][7:0] = reg_req.wdata;
      end else if (reg_req.addr == `ADDR_PS1_HI) begin
        res_nxt[`SLOT_PS1][15:8] = reg_req.wdata;
      end else if (reg_req.addr == `ADDR_PS2_LO) begin
        res_nxt[`SLOT_PS2][7:0] = reg_req.wdata;
      end else if (reg_req.addr == `ADDR_PS2_HI) begin
        res_nxt[`SLOT_PS2][15:8] = reg_req.wdata;
      end
    end
    // A finished measurement replaces both bytes in one step, host must have read first
    if (meas.valid) begin
      case (meas.chan)
        CH_VIS: res_nxt[`SLOT_VIS] = meas.value; // [RQ12]
        CH_IR: res_nxt[`SLOT_IR] = meas.value; // [RQ12]
        CH_PS1: res_nxt[`SLOT_PS1] = meas.value; // [RQ12]
        CH_PS2: res_nxt[`SLOT_PS2] = meas.value; // [RQ12]
        // Channel three and unknown codes leave every word, and any host write, alone
        default: begin
        end
      endcase
    end
  end

  // Read data decode, unmapped addresses read zero
  // Reading has no side effect, so a repeated read returns the same byte
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_req.rd) begin
      if (reg_req.addr == `ADDR_IRQ_FLAGS) begin
        rdata_nxt = {2'h0, flags_r}; // [RQ1]
      end else if (reg_req.addr == `ADDR_VIS_LO) begin
        rdata_nxt = res_r[`SLOT_VIS][7:0]; // [RQ6]
      end else if (reg_req.addr == `ADDR_VIS_HI) begin
        rdata_nxt = res_r[`SLOT_VIS][15:8]; // [RQ6]
      end else if (reg_req.addr == `ADDR_IR_LO) begin
        rdata_nxt = res_r[`SLOT_IR][7:0]; // [RQ7]
      end else if (reg_req.addr == `ADDR_IR_HI) begin
        rdata_nxt = res_r[`SLOT_IR][15:8]; // [RQ7]
      end else if (reg_req.addr == `ADDR_PS1_LO) begin
        rdata_nxt = res_r[`SLOT_PS1][7:0]; // [RQ8]
      end else if (reg_req.addr == `ADDR_PS1_HI) begin
        rdata_nxt = res_r[`SLOT_PS1][15:8]; // [RQ8]
      end else if (reg_req.addr == `ADDR_PS2_LO) begin
        rdata_nxt = res_r[`SLOT_PS2][7:0]; // [RQ9]
      end else if (reg_req.addr == `ADDR_PS2_HI) begin
        rdata_nxt = res_r[`SLOT_PS2][15:8]; // [RQ11]
      end else begin
        rdata_nxt = `RST_BYTE;
      end
    end
  end

  // Flags and interrupt line, all zero out of reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= `RST_FLAGS; // [RQ10]
      int_r <= 1'b0; // [RQ10]
    end else begin
      flags_r <= flags_nxt;
      int_r <= int_nxt;
    end
  end

  // Result words, all zero out of reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `SLOT_N; i++) begin
        res_r[i] <= `RST_WORD; // [RQ10]
      end
    end else begin
      for (int i = 0; i < `SLOT_N; i++) begin
        res_r[i] <= res_nxt[i];
      end
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= `RST_BYTE; // [RQ10]
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs come straight from flip-flops
  assign reg_rdata = rdata_r;
  assign host_int = int_r;

  // Checks on this block's own behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Status byte and interrupt line
  a_reserved_zero: assert property ( // [RQ1]
    reg_req.rd && reg_req.addr == `ADDR_IRQ_FLAGS |=> reg_rdata[7:6] == 2'h0 && reg_rdata[5:0] == $past(flags_r))
    else $error("status byte read wrong");
  a_int_level: assert property ( // [RQ2]
    host_int == |(flags_r & $past(irq_enable)))
    else $error("interrupt line does not match enabled flags");
  a_als_code: assert property ( // [RQ1]
    meas.valid && (meas.chan == CH_VIS || meas.chan == CH_IR)
    |=> (flags_r[`ALS_HI:`ALS_LO] & $past(meas.als_code)) == $past(meas.als_code))
    else $error("ambient light code not latched");
  a_cmd_set: assert property ( // [RQ1]
    cmd_done |=> flags_r[`BIT_CMD])
    else $error("command completion flag not set");

  // Clear policies
  a_w1c_clear: assert property ( // [RQ3]
    !int_mode && status_wr && reg_req.wdata[`BIT_PS1] && !(meas.valid && meas.chan == CH_PS1)
    |=> !flags_r[`BIT_PS1])
    else $error("write one did not clear proximity one flag");
  a_flag_sticky: assert property ( // [RQ3]
    !int_mode && flags_r[`BIT_CMD] && !(status_wr && reg_req.wdata[`BIT_CMD]) |=> flags_r[`BIT_CMD])
    else $error("command flag lost without a clear");
  a_set_wins: assert property ( // [RQ3]
    cmd_done && status_wr && reg_req.wdata[`BIT_CMD] |=> flags_r[`BIT_CMD])
    else $error("clear beat a simultaneous set");
  a_auto_clear: assert property ( // [RQ4]
    int_mode && auto_clear && !meas.valid && !cmd_done |=> flags_r[`BIT_CMD] == 1'b0 && flags_r[1:0] == 2'h0)
    else $error("automatic clear left a flag set");
  a_auto_keep: assert property ( // [RQ4]
    int_mode && auto_clear && proximity_irq_condition[0] == `COND_KEEP && flags_r[`BIT_PS1] && !status_wr
    |=> flags_r[`BIT_PS1])
    else $error("automatic clear dropped a held proximity flag");
  a_auto_keep_two: assert property ( // [RQ4]
    int_mode && auto_clear && proximity_irq_condition[1] == `COND_KEEP && flags_r[`BIT_PS2] && !status_wr
    |=> flags_r[`BIT_PS2])
    else $error("automatic clear dropped held proximity two flag");
  a_auto_keep_three: assert property ( // [RQ4]
    int_mode && auto_clear && proximity_irq_condition[2] == `COND_KEEP && flags_r[`BIT_PS3] && !status_wr
    |=> flags_r[`BIT_PS3])
    else $error("automatic clear dropped held proximity three flag");
  a_auto_drop: assert property ( // [RQ4]
    int_mode && auto_clear && proximity_irq_condition[1] != `COND_KEEP && !(meas.valid && meas.chan == CH_PS2)
    |=> !flags_r[`BIT_PS2])
    else $error("automatic clear kept an unheld proximity two flag");

  // Result bytes as the host reads them
  a_vis_lo_read: assert property ( // [RQ6]
    reg_req.rd && reg_req.addr == `ADDR_VIS_LO |=> reg_rdata == $past(res_r[`SLOT_VIS][7:0]))
    else $error("visible low byte read wrong");
  a_ir_hi_read: assert property ( // [RQ7]
    reg_req.rd && reg_req.addr == `ADDR_IR_HI |=> reg_rdata == $past(res_r[`SLOT_IR][15:8]))
    else $error("infrared high byte read wrong");
  a_ps1_lo_read: assert property ( // [RQ8]
    reg_req.rd && reg_req.addr == `ADDR_PS1_LO |=> reg_rdata == $past(res_r[`SLOT_PS1][7:0]))
    else $error("proximity one low byte read wrong");
  a_vis_read: assert property ( // [RQ6]
    reg_req.rd && reg_req.addr == `ADDR_VIS_HI |=> reg_rdata == $past(res_r[`SLOT_VIS][15:8]))
    else $error("visible high byte read wrong");
  a_ir_read: assert property ( // [RQ7]
    reg_req.rd && reg_req.addr == `ADDR_IR_LO |=> reg_rdata == $past(res_r[`SLOT_IR][7:0]))
    else $error("infrared low byte read wrong");
  a_ps1_read: assert property ( // [RQ8]
    reg_req.rd && reg_req.addr == `ADDR_PS1_HI |=> reg_rdata == $past(res_r[`SLOT_PS1][15:8]))
    else $error("proximity one high byte read wrong");
  a_ps2_lo_read: assert property ( // [RQ9]
    reg_req.rd && reg_req.addr == `ADDR_PS2_LO |=> reg_rdata == $past(res_r[`SLOT_PS2][7:0]))
    else $error("proximity two low byte read wrong");
  a_ps2_hi_read: assert property ( // [RQ11]
    reg_req.rd && reg_req.addr == `ADDR_PS2_HI |=> reg_rdata == $past(res_r[`SLOT_PS2][15:8]))
    else $error("proximity two high byte read wrong");

  // Reset and measurement updates
  a_reset_zero: assert property ( // [RQ10]
    disable iff (1'b0) $rose(arst_n) |-> flags_r == `RST_FLAGS && res_r[`SLOT_PS2] == `RST_WORD && !host_int)
    else $error("state not zero after reset");
  a_word_update: assert property ( // [RQ12]
    meas.valid && meas.chan == CH_PS2 |=> res_r[`SLOT_PS2] == $past(meas.value) && flags_r[`BIT_PS2])
    else $error("word and flag not updated together");
  a_meas_wins: assert property ( // [RQ12]
    meas.valid && meas.chan == CH_PS2 && reg_req.wr && reg_req.addr == `ADDR_PS2_LO
    |=> res_r[`SLOT_PS2][7:0] == $past(meas.value[7:0]))
    else $error("host byte write beat a measurement");
  a_ir_update: assert property ( // [RQ12]
    meas.valid && meas.chan == CH_IR |=> res_r[`SLOT_IR] == $past(meas.value))
    else $error("infrared word not loaded");
  a_ps1_update: assert property ( // [RQ12]
    meas.valid && meas.chan == CH_PS1 |=> res_r[`SLOT_PS1] == $past(meas.value) && flags_r[`BIT_PS1])
    else $error("proximity one word and flag not updated together");
  a_vis_update: assert property ( // [RQ12]
    meas.valid && meas.chan == CH_VIS |=> res_r[`SLOT_VIS] == $past(meas.value))
    else $error("visible word not loaded");

  // Main scenarios
  c_ps_irq: cover property (meas.valid && meas.chan == CH_PS1 && irq_enable[`BIT_PS1] ##1 host_int);
  c_host_clear: cover property (host_int && status_wr ##1 !host_int);
  c_auto_keep: cover property (int_mode && auto_clear && flags_r[`BIT_PS2] ##1 flags_r[`BIT_PS2]);
  c_read_pair: cover property (reg_req.rd && reg_req.addr == `ADDR_VIS_LO ##1 reg_req.rd && reg_req.addr == `ADDR_VIS_HI);
  c_set_wins: cover property (cmd_done && status_wr && reg_req.wdata[`BIT_CMD] ##1 flags_r[`BIT_CMD]);

endmodule : light_prox_irq_results

`default_nettype wire

// [tb/light_prox_host.sv]
// Host model: single-byte register reads and writes on the register port.
// Assumes clk_sys is shared with the block; requests launch 1 ns after a rising edge.
`default_nettype none

module light_prox_host
  import light_prox_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Register port towards the block
  output var reg_req_t reg_req,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle port at time zero
  initial begin
    reg_req = '0;
  end

  // Write one byte; writing ones to status bits clears those flags
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    #1;
    // Released lines show the inverse, never the stale value
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr

  // Read one byte; t_results fetches both result bytes right after each event
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    #1;
    d = reg_rdata;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
  endtask : rd

endmodule : light_prox_host

`default_nettype wire

// [tb/test_light_prox_irq_results.sv]
// Bench for the status flags, interrupt line and result bytes.
// Assumes the host model drives the register port; this module plays the sequencer.
`default_nettype none

module test_light_prox_irq_results
  import light_prox_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys, arst_n, cmd_done, auto_clear, int_mode, host_int;
  reg_req_t reg_req;
  logic [7:0] reg_rdata;
  meas_t meas;
  logic [5:0] irq_enable;
  logic [1:0] cond [3];
  int mismatches, checks;

  light_prox_irq_results light_prox_irq_results_i (.clk_sys(clk_sys), .arst_n(arst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .meas(meas), .cmd_done(cmd_done), .auto_clear(auto_clear), .irq_enable(irq_enable),
    .int_mode(int_mode), .proximity_irq_condition(cond), .host_int(host_int));
  light_prox_host light_prox_host_i (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata));

  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Byte comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Register read then compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    light_prox_host_i.rd(a, d);
    chk(d, exp, "register read");
  endtask : rchk

  // One-cycle sequencer event
  task automatic seq(input logic mv, input meas_chan_t c, input logic [15:0] v, input logic [1:0] k,
                     input logic cd, input logic ac);
    @(posedge clk_sys);
    #1;
    meas = '{mv, c, v, k};
    cmd_done = cd;
    auto_clear = ac;
    @(posedge clk_sys);
    #1;
    meas = '0;
    cmd_done = 1'b0;
    auto_clear = 1'b0;
  endtask : seq

  // All registers zero after reset, unmapped place reads zero
  task automatic t_reset;
    for (int a = 8'h21; a <= 8'h2A; a++) begin
      rchk(8'(a), 8'h00);
    end
    chk({7'h00, host_int}, 8'h00, "interrupt idle");
    $display("test reset done");
  endtask : t_reset

  // Every result channel lands in its byte pair with its flag
  task automatic t_results;
    logic [15:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 16'hC3A5 + 16'(16'h1111 * i);
      seq(1'b1, meas_chan_t'(i), v, (i < 2) ? 2'(i + 1) : 2'h0, 1'b0, 1'b0);
      rchk(8'h22 + 8'(2 * i), v[7:0]);
      rchk(8'h23 + 8'(2 * i), v[15:8]);
    end
    rchk(8'h21, 8'h0F);
    chk({7'h00, host_int}, 8'h00, "interrupt masked");
    seq(1'b1, CH_PS3, 16'h0000, 2'h0, 1'b1, 1'b0);
    rchk(8'h21, 8'h3F);
    $display("test results done");
  endtask : t_results

  // Write-one clear drives the line down
  task automatic t_irq;
    irq_enable = 6'h08;
    light_prox_host_i.wr(8'h21, 8'hF7);
    chk({7'h00, host_int}, 8'h01, "interrupt on");
    rchk(8'h21, 8'h08);
    light_prox_host_i.wr(8'h21, 8'h08);
    chk({7'h00, host_int}, 8'h00, "interrupt off");
    rchk(8'h21, 8'h00);
    $display("test irq done");
  endtask : t_irq

  // Automatic clear, with channel two kept by its condition field
  task automatic t_auto;
    irq_enable = 6'h3F;
    cond[1] = 2'h3;
    seq(1'b1, CH_PS1, 16'h1234, 2'h0, 1'b0, 1'b0);
    seq(1'b1, CH_PS2, 16'h5678, 2'h0, 1'b1, 1'b0);
    seq(1'b0, CH_VIS, 16'h0000, 2'h0, 1'b0, 1'b1);
    rchk(8'h21, 8'h2C);
    int_mode = 1'b1;
    seq(1'b0, CH_VIS, 16'h0000, 2'h0, 1'b0, 1'b1);
    rchk(8'h21, 8'h08);
    chk({7'h00, host_int}, 8'h01, "interrupt kept");
    cond[1] = 2'h0;
    seq(1'b0, CH_VIS, 16'h0000, 2'h0, 1'b0, 1'b1);
    chk({7'h00, host_int}, 8'h00, "interrupt auto off");
    rchk(8'h21, 8'h00);
    cond[0] = 2'h3;
    cond[2] = 2'h3;
    seq(1'b1, CH_PS1, 16'h0042, 2'h0, 1'b0, 1'b0);
    seq(1'b1, CH_PS3, 16'h0000, 2'h0, 1'b0, 1'b0);
    seq(1'b0, CH_VIS, 16'h0000, 2'h0, 1'b0, 1'b1);
    rchk(8'h21, 8'h14);
    chk({7'h00, host_int}, 8'h01, "interrupt held");
    light_prox_host_i.wr(8'h21, 8'h14);
    rchk(8'h21, 8'h00);
    cond = '{2'h0, 2'h0, 2'h0};
    $display("test auto done");
  endtask : t_auto

  // Host byte writes, then a measurement and a set meeting a host write in one cycle
  task automatic t_write;
    int_mode = 1'b0;
    for (int a = 8'h22; a <= 8'h29; a++) begin
      light_prox_host_i.wr(8'(a), 8'(a) ^ 8'h5A);
      rchk(8'(a), 8'(a) ^ 8'h5A);
    end
    light_prox_host_i.wr(8'h21, 8'hC0);
    rchk(8'h21, 8'h00);
    fork
      light_prox_host_i.wr(8'h28, 8'hAA);
      seq(1'b1, CH_PS2, 16'h1357, 2'h0, 1'b0, 1'b0);
    join
    rchk(8'h28, 8'h57);
    rchk(8'h29, 8'h13);
    fork
      light_prox_host_i.wr(8'h21, 8'h28);
      seq(1'b0, CH_VIS, 16'h0000, 2'h0, 1'b1, 1'b0);
    join
    rchk(8'h21, 8'h20);
    light_prox_host_i.wr(8'h21, 8'h20);
    rchk(8'h21, 8'h00);
    $display("test write done");
  endtask : t_write

  // Reset in mid-run brings the status byte, both infrared bytes and the line back to zero
  task automatic t_rearm;
    seq(1'b1, CH_IR, 16'hBEEF, 2'h3, 1'b1, 1'b0);
    chk({7'h00, host_int}, 8'h01, "interrupt before reset");
    rchk(8'h25, 8'hBE);
    @(posedge clk_sys);
    #1;
    arst_n = 1'b0;
    @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    chk({7'h00, host_int}, 8'h00, "interrupt after reset");
    rchk(8'h21, 8'h00);
    rchk(8'h24, 8'h00);
    rchk(8'h25, 8'h00);
    $display("test rearm done");
  endtask : t_rearm

  // Verdict and end of run
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    mismatches = 0;
    checks = 0;
    arst_n = 1'b0;
    meas = '0;
    cmd_done = 1'b0;
    auto_clear = 1'b0;
    int_mode = 1'b0;
    irq_enable = 6'h00;
    cond = '{2'h0, 2'h0, 2'h0};
    repeat (4) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_results();
    t_irq();
    t_auto();
    t_write();
    t_rearm();
    conclude();
  end

endmodule : test_light_prox_irq_results

`default_nettype wire
